/* rtl/scg_gate.sv */
// sleep-mode clock gate control with ahb-lite register slave and unit access fault check
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// How it works
// - gate bit one enables the unit clock, zero leaves it unclocked and disabled.
// - access to a unit whose clock is off raises unit_fault and a sticky status bit; hresp stays okay.
// - gate bits reset to zero unless their own reset value differs.
// - three gating registers exist; this one applies while in sleep mode.
// - sleep gating applies only with auto gating select set, else run gating.
// - bit 16 gates converter 0 in sleep; read-write, resets zero.
// - bit 6 gates hibernation unit in sleep; read-write, resets one.
// - bit 3 gates watchdog in sleep; resets zero; access while clear faults.
// - reserved bits are read-only and read as zero.
module scg_gate #(
   parameter logic [1:0] MAX_RATE = 2'h2
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        sleep_req,
   input  wire logic        unit_access,
   input  wire logic [1:0]  unit_sel,
   output logic             unit_fault,
   output logic             wdt_clk_en,
   output logic             hib_clk_en,
   output logic             adc_clk_en,
   output logic [1:0]       converter_sample_rate,
   output logic             irq
);
   // refused at elaboration: the clamp cannot serve a ceiling above the fastest code
   if (MAX_RATE > scg_pkg::RATE_500K) begin : g_bad_rate
      $error("MAX_RATE above the fastest supported code");
   end

   logic [31:0] sleep_gate_q;
   logic [31:0] run_gate_q;
   logic [31:0] rcc_q;
   logic        sleep_ctl_q;
   logic [scg_pkg::IRQ_W-1:0] ists_q;
   logic [scg_pkg::IRQ_W-1:0] imask_q;
   logic        wr_pend_q;
   logic [11:0] wr_addr_q;
   logic        s1_q;
   logic        s2_q;
   logic        acc1_q;
   logic        acc2_q;
   logic [1:0]  sel1_q;
   logic [1:0]  sel2_q;

   // sleep pin and unit access arrive from outside the bus domain
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q   <= 1'b0;
         s2_q   <= 1'b0;
         acc1_q <= 1'b0;
         acc2_q <= 1'b0;
         sel1_q <= 2'h0;
         sel2_q <= 2'h0;
      end else begin
         s1_q   <= sleep_req;
         s2_q   <= s1_q;
         acc1_q <= unit_access;
         acc2_q <= acc1_q;
         sel1_q <= unit_sel;
         sel2_q <= sel1_q;
      end
   end

   function automatic logic [1:0] clamp_rate(input logic [1:0] r);
      if (r > MAX_RATE) begin
         clamp_rate = MAX_RATE;
      end else begin
         clamp_rate = r;
      end
   endfunction : clamp_rate

   // address phase decode
   wire        addr_ok  = hsel && hready && htrans[1];
   wire        wr_take  = addr_ok && hwrite;
   wire [11:0] a        = haddr[11:0];
   wire        in_sleep = s2_q || sleep_ctl_q;
   // sleep register only applies when auto gating is selected
   wire        use_sleep = in_sleep && rcc_q[scg_pkg::ACG_BIT];
   wire [31:0] active_gate = use_sleep ? sleep_gate_q : run_gate_q;
   wire [31:0] wmask_data = hwdata & scg_pkg::GATE_WMASK;
   wire [1:0]  wr_rate = clamp_rate(hwdata[scg_pkg::RATE_MSB:scg_pkg::RATE_LSB]);

   // unit access fault: selected unit clock currently off
   wire unit_on = (sel2_q == 2'h0) ? active_gate[scg_pkg::WDT_BIT] :
                  (sel2_q == 2'h1) ? active_gate[scg_pkg::HIB_BIT] :
                  active_gate[scg_pkg::ADC_BIT];
   wire fault_now = acc2_q && !unit_on;
   wire [scg_pkg::IRQ_W-1:0] fault_ev = {
      fault_now && (sel2_q[1]),
      fault_now && (sel2_q == 2'h1),
      fault_now && (sel2_q == 2'h0)};

   wire w_sleep = wr_pend_q && (wr_addr_q == scg_pkg::SLEEP_CLOCK_GATE_0_OFS);
   wire w_run   = wr_pend_q && (wr_addr_q == scg_pkg::RUN_CLOCK_GATE_0_OFS);
   wire w_rcc   = wr_pend_q && (wr_addr_q == scg_pkg::RUN_CLOCK_CONFIG_OFS);
   wire w_ists  = wr_pend_q && (wr_addr_q == scg_pkg::INT_STATUS_OFS);
   wire w_imask = wr_pend_q && (wr_addr_q == scg_pkg::INT_MASK_OFS);
   wire w_ctl   = wr_pend_q && (wr_addr_q == scg_pkg::SLEEP_CTRL_OFS);

   wire [31:0] new_gate = {wmask_data[31:10], wr_rate, wmask_data[7:0]};

   // read mux, reserved bits always read zero
   wire [31:0] rd_val =
      (a == scg_pkg::SLEEP_CLOCK_GATE_0_OFS) ? sleep_gate_q :
      (a == scg_pkg::RUN_CLOCK_GATE_0_OFS)   ? run_gate_q :
      (a == scg_pkg::RUN_CLOCK_CONFIG_OFS)   ? rcc_q :
      (a == scg_pkg::INT_STATUS_OFS)   ? {29'h0, ists_q} :
      (a == scg_pkg::INT_MASK_OFS)     ? {29'h0, imask_q} :
      (a == scg_pkg::SLEEP_CTRL_OFS)   ? {31'h0, sleep_ctl_q} : 32'h0000_0000;

   // write data arrives one cycle after the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end else begin
         wr_pend_q <= wr_take;
         wr_addr_q <= a;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_gate_q <= scg_pkg::GATE_RESET;
         run_gate_q   <= scg_pkg::GATE_RESET;
         rcc_q        <= scg_pkg::RCC_RESET;
         sleep_ctl_q  <= 1'b0;
      end else begin
         if (w_sleep) begin
            sleep_gate_q <= new_gate;
         end
         if (w_run) begin
            run_gate_q <= new_gate;
         end
         if (w_rcc) begin
            rcc_q <= hwdata & scg_pkg::RCC_WMASK;
         end
         if (w_ctl) begin
            sleep_ctl_q <= hwdata[scg_pkg::SLEEP_BIT];
         end
      end
   end

   // sticky faults; a new event wins over a write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ists_q  <= scg_pkg::IRQ_RESET;
         imask_q <= scg_pkg::IRQ_RESET;
      end else begin
         ists_q <= (ists_q & ~(w_ists ? hwdata[scg_pkg::IRQ_W-1:0] : 3'h0)) | fault_ev;
         if (w_imask) begin
            imask_q <= hwdata[scg_pkg::IRQ_W-1:0];
         end
      end
   end

   // registered outputs; zero-wait slave, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata     <= 32'h0000_0000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         unit_fault <= 1'b0;
         wdt_clk_en <= 1'b0;
         hib_clk_en <= 1'b1;
         adc_clk_en <= 1'b0;
         converter_sample_rate <= scg_pkg::RATE_125K;
         irq        <= 1'b0;
      end else begin
         hrdata     <= (addr_ok && !hwrite) ? rd_val : 32'h0000_0000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         unit_fault <= fault_now;
         wdt_clk_en <= active_gate[scg_pkg::WDT_BIT];
         hib_clk_en <= active_gate[scg_pkg::HIB_BIT];
         adc_clk_en <= active_gate[scg_pkg::ADC_BIT];
         // rate field lives in the active register too
         converter_sample_rate <= active_gate[scg_pkg::RATE_MSB:scg_pkg::RATE_LSB];
         irq        <= |(ists_q & imask_q);
      end
   end
endmodule : scg_gate

/* rtl/scg_pkg.sv */
// package: register map, field positions and reset values for the sleep clock gate block
package scg_pkg;
   // register byte offsets
   localparam logic [11:0] SLEEP_CLOCK_GATE_0_OFS = 12'h110;
   localparam logic [11:0] RUN_CLOCK_GATE_0_OFS   = 12'h100;
   localparam logic [11:0] RUN_CLOCK_CONFIG_OFS   = 12'h060;
   localparam logic [11:0] INT_STATUS_OFS         = 12'h200;
   localparam logic [11:0] INT_MASK_OFS           = 12'h204;
   localparam logic [11:0] SLEEP_CTRL_OFS         = 12'h208;
   // field positions
   localparam int WDT_BIT      = 3;
   localparam int HIB_BIT      = 6;
   localparam int RATE_LSB     = 8;
   localparam int RATE_MSB     = 9;
   localparam int ADC_BIT      = 16;
   localparam int ACG_BIT      = 27;
   localparam int SLEEP_BIT    = 0;
   // writable bits and reset values of the gate and run config registers
   localparam logic [31:0] GATE_WMASK    = 32'h0001_0348;
   localparam logic [31:0] GATE_RESET    = 32'h0000_0040;
   localparam logic [31:0] RCC_WMASK     = 32'h0800_0000;
   localparam logic [31:0] RCC_RESET     = 32'h0000_0000;
   // interrupt status bits: fault on watchdog, hibernation, converter access
   localparam int IRQ_WDT_FAULT = 0;
   localparam int IRQ_HIB_FAULT = 1;
   localparam int IRQ_ADC_FAULT = 2;
   localparam int IRQ_W         = 3;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
   // converter rate codes
   localparam logic [1:0] RATE_125K = 2'h0;
   localparam logic [1:0] RATE_250K = 2'h1;
   localparam logic [1:0] RATE_500K = 2'h2;
endpackage : scg_pkg

/* test/scg_gate_properties.sv */
// checker: bus, enable and fault properties of the sleep clock gate
`timescale 1ns/1ns
module scg_checker (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hrdata,
   input wire logic        sleep_req,
   input wire logic        unit_access,
   input wire logic        unit_fault,
   input wire logic        wdt_clk_en,
   input wire logic        hib_clk_en,
   input wire logic        adc_clk_en,
   input wire logic [1:0]  converter_sample_rate
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire        rd = hsel && htrans[1] && !hwrite;
   wire        gate_rd = rd && haddr[11:0] == scg_pkg::SLEEP_CLOCK_GATE_0_OFS;
   logic [3:0] quiet_q;
   // enables may move only shortly after an access or a sleep change
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn) quiet_q <= 4'h0;
      else quiet_q <= (hsel && htrans[1]) || $changed(sleep_req) ? 4'h0
                      : quiet_q + 4'(quiet_q < 4'hf);
   AST_RD_IDLE: assert property (!rd |=> hrdata == 32'h0) else $error("stray data");
   AST_RSVD: assert property (gate_rd |=> (hrdata & ~scg_pkg::GATE_WMASK) == 32'h0)
      else $error("reserved bit set");
   AST_RD_RATE: assert property (gate_rd |=> hrdata[9:8] != 2'h3) else $error("bad rate");
   AST_RATE: assert property (converter_sample_rate != 2'h3) else $error("rate high");
   AST_RESET: assert property ($rose(hresetn) |-> hib_clk_en && !wdt_clk_en && !adc_clk_en)
      else $error("bad reset enables");
   AST_EN: assert property ($changed({wdt_clk_en, hib_clk_en, adc_clk_en}) |-> quiet_q < 4'h6)
      else $error("enable moved");
   AST_FAULT: assert property (unit_fault |-> $past(unit_access, 3)) else $error("no access");
   AST_QUIET: assert property (!unit_access [*4] |=> !unit_fault) else $error("late fault");
endmodule : scg_checker
bind scg_gate scg_checker chk (.*);

/* test/test_sleep_mode_clock_gating.sv */
// self-checking bench for the sleep clock gate block
`timescale 1ns/1ns
module test_sleep_mode_clock_gating;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, rd_pend;
   logic        sleep_req, unit_access, unit_fault, wdt_clk_en, hib_clk_en, adc_clk_en;
   logic [31:0] haddr, hwdata, hrdata, d, exp_q[$];
   logic [1:0]  htrans, unit_sel, converter_sample_rate;
   logic [2:0]  hsize;
   int          fails, comparisons, cycles;
   assign hready = hreadyout;
   scg_gate dut (.*);
   initial forever #5 hclk = ~hclk;
   task automatic check(input logic [31:0] seen, want);
      comparisons++;
      if (seen !== want) begin
         fails++;
         $display("mismatch %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic wrap_up();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task automatic pins(input logic [4:0] e);
      check({27'h0, wdt_clk_en, hib_clk_en, adc_clk_en, converter_sample_rate}, {27'h0, e});
   endtask : pins
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, e);
      @(posedge hclk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 20'h0, a};
      do @(posedge hclk); while (!hreadyout);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
      if (!w) exp_q.push_back(e);
      do @(posedge hclk); while (!hreadyout);
   endtask : bus
   always @(posedge hclk) begin
      if (++cycles == 2000) begin
         fails++;
         wrap_up();
      end
      if (rd_pend) check(hrdata, exp_q.pop_front());
      if (rd_pend) check({30'h0, hreadyout, hresp}, 32'h2);
      rd_pend <= hsel && htrans[1] && !hwrite;
   end
   initial begin
      {hclk, hresetn, hsel, hwrite, sleep_req, unit_access, rd_pend} = '0;
      {haddr, hwdata, htrans, unit_sel} = '0;
      hsize = 3'h2;
      void'($urandom(32'h01c8));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      pins(5'h08);
      bus(1'b0, scg_pkg::SLEEP_CLOCK_GATE_0_OFS, 32'h0, scg_pkg::GATE_RESET);
      bus(1'b0, 12'h3fc, 32'h0, 32'h0);
      for (int r = 0; r < 8; r++) begin
         d = $urandom;
         d[9:8] = r[1:0];
         bus(1'b1, scg_pkg::SLEEP_CLOCK_GATE_0_OFS, d, 32'h0);
         d = d & scg_pkg::GATE_WMASK;
         if (d[9:8] == 2'h3) d[9:8] = scg_pkg::RATE_500K;
         bus(1'b0, scg_pkg::SLEEP_CLOCK_GATE_0_OFS, 32'h0, d);
      end
      // sleep gate: converter on at top rate, watchdog and hibernation off
      bus(1'b1, scg_pkg::SLEEP_CLOCK_GATE_0_OFS, 32'h0001_0200, 32'h0);
      sleep_req <= 1'b1;
      repeat (6) @(posedge hclk);
      pins(5'h08);
      bus(1'b1, scg_pkg::RUN_CLOCK_CONFIG_OFS, 32'h0800_0000, 32'h0);
      repeat (4) @(posedge hclk);
      pins(5'h06);
      unit_access <= 1'b1;
      repeat (6) @(posedge hclk);
      check({31'h0, unit_fault}, 32'h1);
      unit_access <= 1'b0;
      bus(1'b1, scg_pkg::INT_MASK_OFS, 32'h1, 32'h0);
      repeat (2) @(posedge hclk);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, scg_pkg::INT_STATUS_OFS, 32'h1, 32'h0);
      repeat (2) @(posedge hclk);
      check({31'h0, irq}, 32'h0);
      unit_sel    <= 2'h1;
      unit_access <= 1'b1;
      repeat (6) @(posedge hclk);
      check({31'h0, unit_fault}, 32'h1);
      unit_access <= 1'b0;
      repeat (4) @(posedge hclk);
      bus(1'b0, scg_pkg::INT_STATUS_OFS, 32'h0, 32'h2);
      unit_sel    <= 2'h2;
      unit_access <= 1'b1;
      repeat (6) @(posedge hclk);
      check({31'h0, unit_fault}, 32'h0);
      unit_access <= 1'b0;
      bus(1'b1, scg_pkg::SLEEP_CTRL_OFS, 32'h1, 32'h0);
      sleep_req <= 1'b0;
      repeat (6) @(posedge hclk);
      pins(5'h06);
      bus(1'b1, scg_pkg::SLEEP_CTRL_OFS, 32'h0, 32'h0);
      repeat (4) @(posedge hclk);
      pins(5'h08);
      bus(1'b1, scg_pkg::RUN_CLOCK_GATE_0_OFS, 32'h0000_0108, 32'h0);
      repeat (4) @(posedge hclk);
      pins(5'h11);
      wrap_up();
   end
endmodule : test_sleep_mode_clock_gating
